// ---- inc/pump_sequencer_map.svh ----
`ifndef PUMP_SEQUENCER_MAP_SVH
`define PUMP_SEQUENCER_MAP_SVH

// ****************************************
// Delay settings, in whole seconds
// ****************************************
`define DELAY_W 17
`define DELAY_MAX 17'h1869F
`define DELAY_DEFAULT 17'h00000

// ****************************************
// Encoded state numbers
// ****************************************
`define ST_NUM_UNUSED 3'h0
`define ST_NUM_READY 3'h1
`define ST_NUM_PRESTART 3'h2
`define ST_NUM_STARTING 3'h3
`define ST_NUM_RUNNING 3'h4
`define ST_NUM_STOPPING 3'h5
`define ST_NUM_DISABLED 3'h6
`define ST_NUM_FAILED 3'h7

// ****************************************
// Timing: one-second tick from the core clock
// ****************************************
`define ONE_SECOND_NS 1000000000
`define CLK_PERIOD_NS 40
`define TICK_W 25

// ****************************************
// Sampled input positions
// ****************************************
`define IN_W 5
`define IN_RUN 0
`define IN_STARTED 1
`define IN_FAULT 2
`define IN_RESET 3
`define IN_LOCKOUT 4

`endif

// ---- inc/pump_sequencer_pkg.sv ----
package pump_sequencer_pkg;

    // ****************************************
    // Sequencer states, one-hot
    // ****************************************
    typedef enum logic [6:0] {
        S_READY = 7'h01,
        S_PRESTART = 7'h02,
        S_STARTING = 7'h04,
        S_RUNNING = 7'h08,
        S_STOPPING = 7'h10,
        S_DISABLED = 7'h20,
        S_FAILED = 7'h40
    } state_t;

endpackage : pump_sequencer_pkg

// ---- design/input_sampler.sv ----
`include "pump_sequencer_map.svh"

// ****************************************
// Input sampler: current and previous samples
// ****************************************
module input_sampler #(
    parameter int W = `IN_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Raw inputs and samples
    input wire logic [W-1:0] d,
    output logic [W-1:0] cur,
    output logic [W-1:0] prev
);

    // Sample once per cycle, keep the previous sample for edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
            prev <= '0;
        end else begin
            cur <= d;
            prev <= cur;
        end
    end

endmodule : input_sampler

// ---- design/delay_timer.sv ----
`include "pump_sequencer_map.svh"

// ****************************************
// Seconds down-counter, loaded on state entry
// ****************************************
module delay_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // One-second tick
    input wire logic tick,
    // Load strobe and delay in seconds
    input wire logic load,
    input wire logic [`DELAY_W-1:0] value,
    // Expired level
    output logic done
);

    logic [`DELAY_W-1:0] cnt; // Seconds left
    logic active; // Loaded since reset

    // Load clamps to the top of the range, tick counts down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= `DELAY_DEFAULT;
            active <= 1'b0;
        end else if (load) begin
            cnt <= (value > `DELAY_MAX) ? `DELAY_MAX : value;
            active <= 1'b1;
        end else if (tick && cnt != `DELAY_DEFAULT) begin
            cnt <= cnt - 1'b1;
        end
    end

    assign done = active && (cnt == `DELAY_DEFAULT);

endmodule : delay_timer

// ---- design/pump_sequencer.sv ----
`include "pump_sequencer_map.svh"

// Overview of operation
// RULE_01: Starts in ready with drive off
// RULE_02: State number 0 unused through 7 failed
// RULE_03: Run request steers toward running or ready
// RULE_04: Pump raises started feedback once energised in starting
// RULE_05: Fault in starting/running/stopping means failed
// RULE_06: Fault in ready/disabled waits for prestart
// RULE_07: Lockout moves active states to disabled
// RULE_08: Lockout drops drive; release returns ready
// RULE_09: Drive high only running or stopping
// RULE_10: One indicator flag per state
// RULE_11: Prestart runs start delay, then starting
// RULE_12: Starting waits feedback; timeout means failed
// RULE_13: Run request drop begins stopping; prestart and starting return to ready instead
// RULE_14: Stopping: request resumes, expiry gives ready
// RULE_15: Failed watches manual reset rising edge
// RULE_16: Feedback timeout cleared only by reset
// RULE_17: Auto reset clears when fault falls
// RULE_18: Manual mode needs fault low plus edge
// RULE_19: Start delay 0 to 99999 seconds
// RULE_20: Stop delay 0 to 99999 seconds
// RULE_21: Feedback delay timeout fails, drive off
// RULE_22: Each feedback restarts feedback timer
// RULE_23: Inputs sampled per cycle, one-second tick
module pump_sequencer #(
    parameter int TICK_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RSTN,
    // Control inputs
    input wire logic RUN_REQ,
    input wire logic DEVICE_STARTED_IN,
    input wire logic FAULT_IN,
    input wire logic RESET_IN,
    input wire logic LOCKOUT_IN,
    // Configuration
    input wire logic [`DELAY_W-1:0] START_DELAY,
    input wire logic [`DELAY_W-1:0] STOP_DELAY,
    input wire logic [`DELAY_W-1:0] FEEDBACK_DELAY,
    input wire logic AUTO_RESET,
    // Device drive
    output logic DRIVE,
    // State indicators
    output logic READY_FLAG,
    output logic PRESTART_STATE_FLAG,
    output logic STARTING_STATE_FLAG,
    output logic RUNNING_FLAG,
    output logic STOPPING_FLAG,
    output logic FAILED_FLAG,
    output logic DISABLED_FLAG,
    output logic [2:0] STATE_NUMBER_OUT
);

    // ****************************************
    // Declarations
    // ****************************************
    pump_sequencer_pkg::state_t state; // Current state
    pump_sequencer_pkg::state_t next_state; // Next state
    logic [`IN_W-1:0] in_cur; // This cycle's samples
    logic [`IN_W-1:0] in_prev; // Last cycle's samples
    logic run_s; // Sampled run request
    logic started_s; // Sampled feedback
    logic fault_s; // Sampled fault
    logic lock_s; // Sampled lockout
    logic reset_rise; // Manual reset edge
    logic [`TICK_W-1:0] tick_cnt; // Divider
    logic tick; // One-second pulse
    logic fb_cause; // Failure from feedback timeout
    logic next_fb_cause; // Next failure cause
    logic start_done; // Start delay expired
    logic stop_done; // Stop delay expired
    logic fb_done; // Feedback delay expired
    logic start_load; // Enter prestart
    logic stop_load; // Enter stopping
    logic fb_load; // Arm or restart feedback timer

    // ****************************************
    // Input sampling and edges
    // ****************************************
    input_sampler #(
        .W(`IN_W)
    ) u_sampler (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .d({LOCKOUT_IN, RESET_IN, FAULT_IN, DEVICE_STARTED_IN, RUN_REQ}),
        .cur(in_cur),
        .prev(in_prev)
    ); // [RULE_23]

    assign run_s = in_cur[`IN_RUN];
    assign started_s = in_cur[`IN_STARTED]; // [RULE_04]
    assign fault_s = in_cur[`IN_FAULT];
    assign lock_s = in_cur[`IN_LOCKOUT];
    // Edge against last cycle's sample
    assign reset_rise = in_cur[`IN_RESET] && !in_prev[`IN_RESET]; // [RULE_15]

    // ****************************************
    // One-second tick
    // ****************************************
    // Free-running, so the first second after a load may be short
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else if (tick_cnt == `TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt <= '0;
            tick <= 1'b1; // [RULE_23]
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
            tick <= 1'b0;
        end
    end

    // ****************************************
    // Delay timers
    // ****************************************
    assign start_load = next_state == pump_sequencer_pkg::S_PRESTART
        && state != pump_sequencer_pkg::S_PRESTART;
    assign stop_load = next_state == pump_sequencer_pkg::S_STOPPING
        && state != pump_sequencer_pkg::S_STOPPING;
    // Armed on entry to starting or running, restarted by feedback
    assign fb_load = (next_state == pump_sequencer_pkg::S_STARTING
        && state != pump_sequencer_pkg::S_STARTING)
        || (next_state == pump_sequencer_pkg::S_RUNNING
        && (state != pump_sequencer_pkg::S_RUNNING || started_s)); // [RULE_22]

    delay_timer u_start_timer (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .tick(tick),
        .load(start_load),
        .value(START_DELAY),
        .done(start_done)
    ); // [RULE_19]

    delay_timer u_stop_timer (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .tick(tick),
        .load(stop_load),
        .value(STOP_DELAY),
        .done(stop_done)
    ); // [RULE_20]

    delay_timer u_fb_timer (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .tick(tick),
        .load(fb_load),
        .value(FEEDBACK_DELAY),
        .done(fb_done)
    ); // [RULE_21]

    // ****************************************
    // Next-state logic
    // ****************************************
    // Outside failed: lockout first, then fault, then per-state events
    always_comb begin
        next_state = state;
        next_fb_cause = fb_cause;
        case (state)
            pump_sequencer_pkg::S_READY: begin
                // Fault ignored here
                if (lock_s) begin
                    next_state = pump_sequencer_pkg::S_DISABLED; // [RULE_07]
                end else if (run_s) begin // [RULE_03]
                    next_state = pump_sequencer_pkg::S_PRESTART; // [RULE_11]
                end
            end
            pump_sequencer_pkg::S_PRESTART: begin
                if (lock_s) begin
                    next_state = pump_sequencer_pkg::S_DISABLED; // [RULE_07]
                end else if (fault_s) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_06]
                    next_fb_cause = 1'b0;
                end else if (!run_s) begin
                    // Drive never came on
                    next_state = pump_sequencer_pkg::S_READY; // [RULE_13]
                end else if (start_done) begin
                    next_state = pump_sequencer_pkg::S_STARTING; // [RULE_11]
                end
            end
            pump_sequencer_pkg::S_STARTING: begin
                if (lock_s) begin
                    next_state = pump_sequencer_pkg::S_DISABLED; // [RULE_07]
                end else if (fault_s) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_05]
                    next_fb_cause = 1'b0;
                end else if (!run_s) begin
                    next_state = pump_sequencer_pkg::S_READY; // [RULE_13]
                end else if (started_s) begin
                    next_state = pump_sequencer_pkg::S_RUNNING; // [RULE_12]
                end else if (fb_done) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_12]
                    next_fb_cause = 1'b1;
                end
            end
            pump_sequencer_pkg::S_RUNNING: begin
                if (lock_s) begin
                    // Drive drops at once, no stop delay
                    next_state = pump_sequencer_pkg::S_DISABLED; // [RULE_08]
                end else if (fault_s) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_05]
                    next_fb_cause = 1'b0;
                end else if (!run_s) begin
                    next_state = pump_sequencer_pkg::S_STOPPING; // [RULE_13]
                end else if (!started_s && fb_done) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_21]
                    next_fb_cause = 1'b1;
                end
            end
            pump_sequencer_pkg::S_STOPPING: begin
                if (lock_s) begin
                    next_state = pump_sequencer_pkg::S_DISABLED; // [RULE_07]
                end else if (fault_s) begin
                    next_state = pump_sequencer_pkg::S_FAILED; // [RULE_05]
                    next_fb_cause = 1'b0;
                end else if (run_s) begin
                    next_state = pump_sequencer_pkg::S_RUNNING; // [RULE_14]
                end else if (stop_done) begin
                    next_state = pump_sequencer_pkg::S_READY; // [RULE_14]
                end
            end
            pump_sequencer_pkg::S_DISABLED: begin
                // Fault ignored here
                if (!lock_s) begin
                    next_state = pump_sequencer_pkg::S_READY; // [RULE_08]
                end
            end
            pump_sequencer_pkg::S_FAILED: begin
                if (fb_cause) begin
                    // Timeout: manual edge only
                    if (reset_rise) begin
                        next_state = pump_sequencer_pkg::S_READY; // [RULE_16]
                    end
                end else if (AUTO_RESET) begin
                    if (!fault_s) begin
                        next_state = pump_sequencer_pkg::S_READY; // [RULE_17]
                    end
                end else if (!fault_s && reset_rise) begin
                    next_state = pump_sequencer_pkg::S_READY; // [RULE_18]
                end
            end
            default: begin
                next_state = pump_sequencer_pkg::S_READY;
            end
        endcase
    end

    // ****************************************
    // State register and failure cause
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= pump_sequencer_pkg::S_READY; // [RULE_01]
            fb_cause <= 1'b0;
        end else begin
            state <= next_state;
            fb_cause <= next_fb_cause;
        end
    end

    // ****************************************
    // Registered outputs, aligned with state
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            DRIVE <= 1'b0;
            READY_FLAG <= 1'b1;
            PRESTART_STATE_FLAG <= 1'b0;
            STARTING_STATE_FLAG <= 1'b0;
            RUNNING_FLAG <= 1'b0;
            STOPPING_FLAG <= 1'b0;
            FAILED_FLAG <= 1'b0;
            DISABLED_FLAG <= 1'b0;
            STATE_NUMBER_OUT <= `ST_NUM_READY;
        end else begin
            DRIVE <= next_state[3] || next_state[4]; // [RULE_09]
            READY_FLAG <= next_state[0]; // [RULE_10]
            PRESTART_STATE_FLAG <= next_state[1];
            STARTING_STATE_FLAG <= next_state[2];
            RUNNING_FLAG <= next_state[3];
            STOPPING_FLAG <= next_state[4];
            DISABLED_FLAG <= next_state[5];
            FAILED_FLAG <= next_state[6];
            case (next_state) // [RULE_02]
                pump_sequencer_pkg::S_READY:
                    STATE_NUMBER_OUT <= `ST_NUM_READY;
                pump_sequencer_pkg::S_PRESTART:
                    STATE_NUMBER_OUT <= `ST_NUM_PRESTART;
                pump_sequencer_pkg::S_STARTING:
                    STATE_NUMBER_OUT <= `ST_NUM_STARTING;
                pump_sequencer_pkg::S_RUNNING:
                    STATE_NUMBER_OUT <= `ST_NUM_RUNNING;
                pump_sequencer_pkg::S_STOPPING:
                    STATE_NUMBER_OUT <= `ST_NUM_STOPPING;
                pump_sequencer_pkg::S_DISABLED:
                    STATE_NUMBER_OUT <= `ST_NUM_DISABLED;
                pump_sequencer_pkg::S_FAILED:
                    STATE_NUMBER_OUT <= `ST_NUM_FAILED;
                default:
                    STATE_NUMBER_OUT <= `ST_NUM_UNUSED;
            endcase
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    property p_drive_states;
        DRIVE == (state == pump_sequencer_pkg::S_RUNNING
            || state == pump_sequencer_pkg::S_STOPPING);
    endproperty
    a_drive_states: assert property (p_drive_states) // [RULE_09]
        else $error("Drive outside running or stopping");

    property p_fail_number;
        FAILED_FLAG |-> STATE_NUMBER_OUT == 3'h7;
    endproperty
    a_fail_number: assert property (p_fail_number) // [RULE_02]
        else $error("Failed state number wrong");

    property p_one_flag;
        $onehot({READY_FLAG, PRESTART_STATE_FLAG, STARTING_STATE_FLAG,
            RUNNING_FLAG, STOPPING_FLAG, FAILED_FLAG, DISABLED_FLAG});
    endproperty
    a_one_flag: assert property (p_one_flag) // [RULE_10]
        else $error("Indicator flags not one-hot");

    property p_lockout;
        lock_s && !FAILED_FLAG |=> DISABLED_FLAG && !DRIVE;
    endproperty
    a_lockout: assert property (p_lockout) // [RULE_07]
        else $error("Lockout did not disable");

    property p_fault_fail;
        fault_s && !lock_s && (STARTING_STATE_FLAG || RUNNING_FLAG
            || STOPPING_FLAG) |=> FAILED_FLAG;
    endproperty
    a_fault_fail: assert property (p_fault_fail) // [RULE_05]
        else $error("Fault did not fail");

    property p_fault_ignored;
        READY_FLAG && fault_s && !run_s && !lock_s |=> READY_FLAG;
    endproperty
    a_fault_ignored: assert property (p_fault_ignored) // [RULE_06]
        else $error("Fault acted on in ready");

    property p_auto_reset;
        FAILED_FLAG && !fb_cause && AUTO_RESET && !fault_s |=> READY_FLAG;
    endproperty
    a_auto_reset: assert property (p_auto_reset) // [RULE_17]
        else $error("Auto reset did not clear");

    property p_manual_hold;
        FAILED_FLAG && !fb_cause && !AUTO_RESET && fault_s [*2]
            |=> FAILED_FLAG;
    endproperty
    a_manual_hold: assert property (p_manual_hold) // [RULE_18]
        else $error("Failure cleared with fault high");

    property p_timeout_hold;
        FAILED_FLAG && fb_cause && !reset_rise |=> FAILED_FLAG;
    endproperty
    a_timeout_hold: assert property (p_timeout_hold) // [RULE_16]
        else $error("Timeout failure cleared without reset");

    property p_resume;
        STOPPING_FLAG && run_s && !lock_s && !fault_s |=> RUNNING_FLAG;
    endproperty
    a_resume: assert property (p_resume) // [RULE_14]
        else $error("Run request did not resume");

    c_run: cover property (STARTING_STATE_FLAG ##1 RUNNING_FLAG);
    c_stop: cover property (STOPPING_FLAG ##1 READY_FLAG);
    c_timeout: cover property (FAILED_FLAG && fb_cause);
    c_unlock: cover property (DISABLED_FLAG ##1 READY_FLAG);

endmodule : pump_sequencer

// ---- sim/pump_model.sv ----
`include "pump_sequencer_map.svh"

// ****************************************
// Pump model: started contact and fault contact
// ****************************************
module pump_model #(
    parameter int LAT = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Energise and bench commands
    input wire logic energise,
    input wire logic answer,
    input wire logic fault_cmd,
    // Contacts back to the sequencer
    output logic started,
    output logic fault
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] cnt; // Spin-up cycles
    logic spun; // Shaft up to speed

    // Shaft spins up while energised, stops when not
    always_ff @(negedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            spun <= 1'h0;
        end else if (energise) begin
            if (cnt < LAT) begin
                cnt <= cnt + 4'h1;
            end else begin
                spun <= 1'h1;
            end
        end else begin
            cnt <= 4'h0;
            spun <= 1'h0;
        end
    end

    // Started contact closes only while the pump answers
    assign started = spun && answer;

    // Fault contact follows bench command at once, no race
    assign fault = fault_cmd;
endmodule : pump_model

// ---- sim/pump_sequencer_test.sv ----
`include "pump_sequencer_map.svh"

module pump_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic run = 1'h0;
    logic rst_in = 1'h0;
    logic lock = 1'h0;
    logic auto = 1'h0;
    logic answer = 1'h1; // Pump responds
    logic fault_cmd = 1'h0;
    logic [`DELAY_W-1:0] t_start = 17'h00000;
    logic [`DELAY_W-1:0] t_stop = 17'h00000;
    logic [`DELAY_W-1:0] t_fb = 17'h00002;
    logic started, fault, drive;
    logic [6:0] flags;
    logic [2:0] num;
    int fails = 0;
    int cmp_count = 0;

    always #20 clk = ~clk;

    // ****************************************
    // Design and pump
    // ****************************************
    pump_sequencer #(.TICK_CYCLES(4)) u_pump_sequencer (
        .CORE_CLK(clk), .RSTN(rstn), .RUN_REQ(run),
        .DEVICE_STARTED_IN(started), .FAULT_IN(fault),
        .RESET_IN(rst_in), .LOCKOUT_IN(lock),
        .START_DELAY(t_start), .STOP_DELAY(t_stop),
        .FEEDBACK_DELAY(t_fb), .AUTO_RESET(auto), .DRIVE(drive),
        .READY_FLAG(flags[0]), .PRESTART_STATE_FLAG(flags[1]),
        .STARTING_STATE_FLAG(flags[2]), .RUNNING_FLAG(flags[3]),
        .STOPPING_FLAG(flags[4]), .DISABLED_FLAG(flags[5]),
        .FAILED_FLAG(flags[6]), .STATE_NUMBER_OUT(num));

    pump_model u_pump_model (
        .clk(clk), .rstn(rstn), .energise(flags[2] | drive),
        .answer(answer), .fault_cmd(fault_cmd),
        .started(started), .fault(fault));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Number, drive and one-hot flags all agree
    task automatic chk_state(input logic [2:0] n);
        logic [6:0] f;
        logic d;
        f = 7'h01 << (n - 3'h1);
        d = (n == 3'h4) || (n == 3'h5);
        check({num, drive, flags}, {n, d, f});
    endtask : chk_state

    // Bounded wait for a state
    task automatic wait_num(input logic [2:0] n);
        int i;
        i = 0;
        while (num !== n && i < 200) begin
            cyc(1);
            i++;
        end
        chk_state(n);
    endtask : wait_num

    // State must stand for k cycles
    task automatic hold(input logic [2:0] n, input int k);
        repeat (k) begin
            cyc(1);
            chk_state(n);
        end
    endtask : hold

    task automatic pulse_reset;
        rst_in = 1'h1;
        cyc(2);
        rst_in = 1'h0;
    endtask : pulse_reset

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_run_stop;
        t_stop = 17'h00003;
        run = 1'h1;
        wait_num(3'h2);
        wait_num(3'h3);
        wait_num(3'h4);
        hold(3'h4, 20);
        answer = 1'h0;
        hold(3'h4, 2);
        answer = 1'h1;
        hold(3'h4, 3);
        run = 1'h0;
        wait_num(3'h5);
        hold(3'h5, 3);
        run = 1'h1;
        wait_num(3'h4);
        run = 1'h0;
        wait_num(3'h1);
    endtask : t_run_stop

    task automatic t_prestart;
        t_start = 17'h00003;
        run = 1'h1;
        wait_num(3'h2);
        hold(3'h2, 6);
        run = 1'h0;
        wait_num(3'h1);
        run = 1'h1;
        wait_num(3'h2);
        lock = 1'h1;
        wait_num(3'h6);
        t_start = 17'h00000;
    endtask : t_prestart

    task automatic t_lockout;
        lock = 1'h0;
        wait_num(3'h4);
        lock = 1'h1;
        wait_num(3'h6);
        hold(3'h6, 3);
        run = 1'h0;
        lock = 1'h0;
        wait_num(3'h1);
    endtask : t_lockout

    task automatic t_fault_manual;
        fault_cmd = 1'h1;
        hold(3'h1, 10);
        run = 1'h1;
        wait_num(3'h7);
        run = 1'h0;
        pulse_reset();
        hold(3'h7, 4);
        fault_cmd = 1'h0;
        hold(3'h7, 6);
        pulse_reset();
        wait_num(3'h1);
    endtask : t_fault_manual

    task automatic t_fault_auto;
        auto = 1'h1;
        run = 1'h1;
        wait_num(3'h4);
        fault_cmd = 1'h1;
        wait_num(3'h7);
        run = 1'h0;
        hold(3'h7, 3);
        fault_cmd = 1'h0;
        wait_num(3'h1);
    endtask : t_fault_auto

    task automatic t_timeout;
        answer = 1'h0;
        run = 1'h1;
        wait_num(3'h3);
        wait_num(3'h7);
        run = 1'h0;
        hold(3'h7, 10);
        pulse_reset();
        wait_num(3'h1);
        answer = 1'h1;
    endtask : t_timeout

    // ****************************************
    // Verdict and sequence
    // ****************************************
    task automatic print_verdict;
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        cyc(12);
        chk_state(3'h1);
        rstn = 1'h1;
        hold(3'h1, 3);
        t_run_stop();
        t_prestart();
        t_lockout();
        t_fault_manual();
        t_fault_auto();
        t_timeout();
        print_verdict();
    end

    // Watchdog against a hang
    initial begin
        #(40 * 5000);
        fails++;
        print_verdict();
    end
endmodule : pump_sequencer_test
